// [asr_sram_ctrl.sv]
`timescale 1ns/100ps
module asr_sram_ctrl
	import asr_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              req,
	input  wire logic              req_wr,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   busy,
	output logic                   rd_valid,
	output logic [DATA_W-1:0]      rd_data,
	output logic                   wr_done,
	output logic [ADDR_W-1:0]      addr_in,
	output logic                   chip_on_n,
	output logic                   out_drv_n,
	output logic                   stor_in_n,
	input  wire logic [DATA_W-1:0] io_byt_i,
	output logic [DATA_W-1:0]      io_byt_o,
	output logic                   io_byt_oe_n
);
	asr_timer_if tif ();

	asr_state_t        state;
	asr_state_t        next_state;
	logic [ADDR_W-1:0] next_addr_in;
	logic [DATA_W-1:0] next_io_byt_o;
	logic [DATA_W-1:0] next_rd_data;
	logic              next_chip_on_n;
	logic              next_out_drv_n;
	logic              next_stor_in_n;
	logic              next_oe_n;
	logic              next_busy;
	logic              next_rd_valid;
	logic              next_wr_done;
	logic              wr_cycle;
	logic              next_wr_cycle;

	asr_timer u_timer (
		.clk    (clk),
		.arst_n (arst_n),
		.tif    (tif)
	);

	// an access is taken only from rest; a request while busy is ignored, not queued
	function automatic logic asr_take(input asr_state_t s, input logic r);
		return (s == ASR_IDLE) && r;
	endfunction

	// a read closes once the full access time has run with the output drive enable low
	function automatic logic asr_read_end(input asr_state_t s, input logic d);
		return (s == ASR_RD) && d;
	endfunction

	// a write closes once the store strobe has been low for the full access time
	function automatic logic asr_write_end(input asr_state_t s, input logic d);
		return (s == ASR_WR) && d;
	endfunction

	// timer reload for the state entered, so every wait length sits in one place
	// the waits are worst-case figures: a faster memory only costs idle cycles
	function automatic logic [CNT_W-1:0] asr_wait_of(input asr_state_t s);
		logic [CNT_W-1:0] w;
		w = '0;
		unique case (s)
			ASR_IDLE: w = '0;
			ASR_SEL:  w = CNT_W'(TURN_CYC);
			ASR_RD:   w = CNT_W'(ACCESS_CYC);
			ASR_WR:   w = CNT_W'(ACCESS_CYC);
			ASR_END:  w = CNT_W'(TURN_CYC);
		endcase
		return w;
	endfunction

	// address and write data: captured once per access and held still to its end
	always_comb begin
		next_addr_in  = addr_in;
		next_io_byt_o = io_byt_o;
		next_wr_cycle = wr_cycle;
		if (asr_take(state, req)) begin
			// a steady address means the read data never floats mid access
			next_addr_in  = req_addr;
			next_io_byt_o = req_wdata;
			next_wr_cycle = req_wr;
		end
	end

	// address registers; the memory sees the last access's address while deselected, zero only after reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_in  <= RST_ADDR;
			io_byt_o <= RST_DATA;
			wr_cycle <= 1'b0;
		end else begin
			addr_in  <= next_addr_in;
			io_byt_o <= next_io_byt_o;
			wr_cycle <= next_wr_cycle;
		end
	end

	// pin sequencer: every pin change goes through a register so pins never glitch
	always_comb begin
		next_state     = state;
		next_chip_on_n = chip_on_n;
		next_out_drv_n = out_drv_n;
		next_stor_in_n = stor_in_n;
		next_oe_n      = io_byt_oe_n;
		unique case (state)
			// rest: memory in standby, bus driven by nobody
			ASR_IDLE: begin
				next_oe_n = 1'b1;
				if (asr_take(state, req)) begin
					// select and direction leave with the address, no ordering needed
					next_chip_on_n = 1'b0;
					next_stor_in_n = 1'b1;
					next_out_drv_n = 1'b1;
					next_state     = ASR_SEL;
				end
			end
			// selected with both enables high: the memory only reads internally
			ASR_SEL: begin
				// wait so the memory's drivers are surely off before we drive
				if (tif.done) begin
					if (wr_cycle) begin
						next_stor_in_n = 1'b0;
						next_oe_n      = 1'b0;
						next_state     = ASR_WR;
					end else begin
						next_out_drv_n = 1'b0;
						next_state     = ASR_RD;
					end
				end
			end
			// read: the memory drives, we only listen
			ASR_RD: begin
				// full access time waited: output float after address change is over
				if (asr_read_end(state, tif.done)) begin
					next_out_drv_n = 1'b1;
					next_chip_on_n = 1'b1;
					next_state     = ASR_END;
				end
			end
			// write: the memory's drivers are off whatever the output drive enable says
			ASR_WR: begin
				// select rises with the strobe, so the store ends on one clean edge
				if (asr_write_end(state, tif.done)) begin
					next_stor_in_n = 1'b1;
					next_chip_on_n = 1'b1;
					next_state     = ASR_END;
				end
			end
			// recovery: data held one cycle past the strobe, then the bus is let go
			ASR_END: begin
				next_oe_n = 1'b1;
				if (tif.done) begin
					next_state = ASR_IDLE;
				end
			end
			// an illegal code falls back to rest
			default: begin
				next_state = ASR_IDLE;
			end
		endcase
	end

	// timer reloads at every state change with the wait of the state entered
	always_comb begin
		tif.load  = (next_state != state);
		tif.value = asr_wait_of(next_state);
	end

	// pin registers; bus released and memory deselected from reset onward
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state       <= ASR_IDLE;
			chip_on_n   <= 1'b1;
			out_drv_n   <= 1'b1;
			stor_in_n   <= 1'b1;
			io_byt_oe_n <= 1'b1;
		end else begin
			state       <= next_state;
			chip_on_n   <= next_chip_on_n;
			out_drv_n   <= next_out_drv_n;
			stor_in_n   <= next_stor_in_n;
			io_byt_oe_n <= next_oe_n;
		end
	end

	// status seen by the requester, kept apart from the pins it reports on
	always_comb begin
		next_busy     = busy;
		next_rd_valid = asr_read_end(state, tif.done);
		next_wr_done  = asr_write_end(state, tif.done);
		next_rd_data  = rd_data;
		// busy falls as the sequencer reaches rest; a request is taken from then on
		if (asr_take(state, req)) begin
			next_busy = 1'b1;
		end else if (state == ASR_END && tif.done) begin
			next_busy = 1'b0;
		end
		// sampled only after the full access, never while the bus may float
		if (asr_read_end(state, tif.done)) begin
			next_rd_data = io_byt_i;
		end
	end

	// status registers; rd_data keeps the last byte read until the next read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy     <= 1'b0;
			rd_valid <= 1'b0;
			wr_done  <= 1'b0;
			rd_data  <= RST_DATA;
		end else begin
			busy     <= next_busy;
			rd_valid <= next_rd_valid;
			wr_done  <= next_wr_done;
			rd_data  <= next_rd_data;
		end
	end
endmodule // asr_sram_ctrl

// [asr_pkg.sv]
package asr_pkg;
	localparam int ADDR_W          = 15;
	localparam int DATA_W          = 8;
	localparam int DEPTH           = 32768;
	localparam int CLK_PERIOD_PS   = 4000;
	// access time of the slowest speed grade
	localparam int ACCESS_NS       = 55;
	localparam int ACCESS_CYC      = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// drive release gap between turning the bus around
	localparam int TURN_NS         = 20;
	localparam int TURN_CYC        = (TURN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W           = 8;
	localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
	localparam logic [ADDR_W-1:0] RST_ADDR = 15'h0000;

	typedef enum logic [2:0] {
		ASR_IDLE  = 3'b000,
		ASR_SEL   = 3'b001,
		ASR_RD    = 3'b011,
		ASR_WR    = 3'b010,
		ASR_END   = 3'b110
	} asr_state_t;
endpackage

// [asr_timer_if.sv]
`timescale 1ns/100ps
interface asr_timer_if;
	import asr_pkg::*;
	logic             load;
	logic [CNT_W-1:0] value;
	logic             done;
	modport ctl (output load, output value, input done);
	modport tmr (input load, input value, output done);
endinterface

// [asr_timer.sv]
`timescale 1ns/100ps
module asr_timer
	import asr_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	asr_timer_if.tmr  tif
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;

	// down counter, done while it rests at zero
	always_comb begin
		next_cnt = cnt;
		if (tif.load) begin
			next_cnt = tif.value;
		end else if (cnt != '0) begin
			next_cnt = cnt - CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// done decodes the count alone, since load itself is derived from done
	assign tif.done = (cnt == '0);
endmodule // asr_timer

// [asr_sram_ctrl_assertions.sv]
`timescale 1ns/100ps
module asr_chk
	import asr_pkg::*;
(
	input wire logic              clk,
	input wire logic              arst_n,
	input wire logic              busy,
	input wire logic              rd_valid,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic              chip_on_n,
	input wire logic              out_drv_n,
	input wire logic              stor_in_n,
	input wire logic              io_byt_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// pin levels in each mode
	a_idle_standby: assert property (!busy |-> chip_on_n && out_drv_n && stor_in_n) else $error("idle");
	a_read_float: assert property (!out_drv_n |-> io_byt_oe_n && stor_in_n && !chip_on_n) else $error("rd");
	a_read_end: assert property (rd_valid |-> chip_on_n && out_drv_n && !$past(out_drv_n)) else $error("end");
	a_write_drive: assert property (!stor_in_n |-> !io_byt_oe_n && !chip_on_n ##1 !io_byt_oe_n) else $error("wr");
	// address held through an access; a change would float the read data
	a_addr_steady: assert property (!chip_on_n && !$past(chip_on_n) |-> $stable(addr_in)) else $error("address moved");
	// never both sides driving the data bus
	a_no_contend: assert property (!io_byt_oe_n |-> out_drv_n) else $error("bus contention");
	c_rd: cover property (rd_valid);
	c_wr: cover property (!stor_in_n);
	c_take: cover property ($rose(busy));
endmodule // asr_chk
bind asr_sram_ctrl asr_chk u_chk (.*);

// [asr_mem_model.sv]
`timescale 1ns/100ps
module asr_mem_model
	import asr_pkg::*;
(
	input wire logic              clk,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic              chip_on_n,
	input wire logic              out_drv_n,
	input wire logic              stor_in_n,
	input wire logic [DATA_W-1:0] io_byt_i,
	output logic                  drv,
	output logic [DATA_W-1:0]     q
);
	logic [DATA_W-1:0] mem [DEPTH];
	int                age;
	logic [ADDR_W-1:0] a_q;
	// bus floats until a full access after select or after an address change
	always @(posedge clk) begin
		a_q <= addr_in;
		age <= (chip_on_n || addr_in !== a_q) ? 0 : age + 1;
	end
	assign drv = !chip_on_n && stor_in_n && !out_drv_n && age >= ACCESS_CYC;
	assign q = mem[addr_in];
	// store as the strobe closes
	always @(posedge stor_in_n) mem[addr_in] = io_byt_i;
endmodule // asr_mem_model

// [asr_sram_ctrl_test.sv]
`timescale 1ns/100ps
module asr_sram_ctrl_test;
	import asr_pkg::*;
	logic              clk, arst_n, req, req_wr, busy, rd_valid, wr_done, chip_on_n, out_drv_n, stor_in_n;
	logic              io_byt_oe_n, drv;
	logic [ADDR_W-1:0] req_addr, addr_in;
	logic [DATA_W-1:0] req_wdata, rd_data, io_byt_o, io_byt_i, q;
	logic [DATA_W-1:0] last = 8'h00;
	logic [DATA_W-1:0] ref_mem [int];
	logic [ADDR_W-1:0] q_a [$];
	int                bad_count, comparisons;
	// nobody driving: show a changing value, not a held one
	assign io_byt_i = !io_byt_oe_n ? io_byt_o : drv ? q : ~last;
	always @(posedge clk) last <= io_byt_i;
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	asr_sram_ctrl DUT (.*);
	asr_mem_model mdl (.*);
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// bounded wait: 0 idle, 1 result pulse, 2 busy
	task wt(input int s);
		for (int n = 0; n < 100; n++) begin
			@(negedge clk);
			if (s == 0 ? busy === 1'b0 : s == 1 ? rd_valid === 1'b1 || wr_done === 1'b1 : busy === 1'b1) return;
		end
		bad_count++;
		$display("mismatch wait_%0d exp done got timeout", s);
		summarize();
	endtask
	// request held while busy with other values, which must be ignored
	task acc(input logic wr, input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] d;
		d = DATA_W'($urandom);
		req_wr = wr;
		req_addr = a;
		req_wdata = d;
		req = 1;
		wt(2);
		comparisons++;
		if (addr_in !== a || chip_on_n !== 1'b0) begin
			bad_count++;
			$display("mismatch addr_in exp %h got %h", a, addr_in);
		end
		req_addr = ~a;
		req_wdata = ~d;
		repeat (3) @(negedge clk);
		req = 0;
		wt(1);
		comparisons++;
		if (wr_done !== wr || rd_valid !== !wr) begin
			bad_count++;
			$display("mismatch done_kind exp %b got %b%b", wr, wr_done, rd_valid);
		end
		if (wr) ref_mem[a] = d;
		else begin
			comparisons++;
			if (rd_data !== ref_mem[a]) begin
				bad_count++;
				$display("mismatch rd_data exp %h got %h", ref_mem[a], rd_data);
			end
		end
		wt(0);
		comparisons++;
		if ({chip_on_n, out_drv_n, stor_in_n, io_byt_oe_n} !== 4'hf) begin
			bad_count++;
			$display("mismatch standby_pins exp f got %h", {chip_on_n, out_drv_n, stor_in_n, io_byt_oe_n});
		end
	endtask
	initial begin
		arst_n = 0;
		req = 0;
		req_wr = 0;
		req_addr = 0;
		req_wdata = 0;
		bad_count = 0;
		comparisons = 0;
		void'($urandom(48548));
		repeat (5) @(negedge clk);
		arst_n = 1;
		for (int i = 0; i < 10; i++) begin
			q_a.push_back(i == 0 ? 15'h0000 : i == 1 ? 15'h7fff : ADDR_W'($urandom));
			acc(1, q_a[i]);
		end
		$display("write test done");
		// reset in mid access: back to standby at once
		req_wr = 0;
		req_addr = q_a[0];
		req = 1;
		wt(2);
		req = 0;
		arst_n = 0;
		@(negedge clk);
		comparisons++;
		if (busy !== 1'b0 || chip_on_n !== 1'b1) begin
			bad_count++;
			$display("mismatch reset_pins exp 01 got %b%b", busy, chip_on_n);
		end
		arst_n = 1;
		$display("reset test done");
		foreach (q_a[i]) acc(0, q_a[i]);
		$display("read test done");
		summarize();
	end
endmodule // asr_sram_ctrl_test
